// ---- shared/phy_regs_pkg.sv ----
// Package: register map, field layout and reset values of the status bank
package phy_regs_pkg;
  // Printed offsets are register indices; byte address is index times four
  localparam logic [7:0]  link_status_index  = 8'h11;
  localparam logic [7:0]  irq_enable_index   = 8'h12;
  localparam logic [7:0]  event_status_index = 8'h13;
  localparam logic [7:0]  irq_control_index  = 8'h20;
  localparam logic [7:0]  event_test_index   = 8'h21;
  localparam logic [9:0]  link_status_addr   = {link_status_index, 2'b00};
  localparam logic [9:0]  irq_enable_addr    = {irq_enable_index, 2'b00};
  localparam logic [9:0]  event_status_addr  = {event_status_index, 2'b00};
  localparam logic [9:0]  irq_control_addr   = {irq_control_index, 2'b00};
  localparam logic [9:0]  event_test_addr    = {event_test_index, 2'b00};
  // Reset values
  localparam logic [15:0] link_status_reset  = 16'h0000;
  localparam logic [15:0] irq_enable_reset   = 16'h0000;
  localparam logic [15:0] event_status_reset = 16'h0000;
  // Control register: bit 0 global enable, bit 13 pin polarity (1 = low)
  localparam int          global_enable_bit  = 0;
  localparam int          polarity_bit       = 13;
  localparam logic [15:0] irq_control_reset  = 16'h2000;
  // Link status field positions
  localparam int          speed_hi_bit       = 15;
  localparam int          speed_lo_bit       = 14;
  localparam int          full_half_bit      = 13;
  localparam int          page_bit           = 12;
  localparam int          resolved_bit       = 11;
  localparam int          link_up_bit        = 10;
  localparam int          cross_cd_bit       = 9;
  localparam int          cross_ab_bit       = 8;
  localparam int          downshift_bit      = 7;
  localparam int          sleep_bit          = 6;
  localparam int          polarity_hi_bit    = 5;
  localparam int          polarity_lo_bit    = 2;
  localparam int          ten_polarity_bit   = 1;
  localparam int          jabber_bit         = 0;
  // Speed codes
  localparam logic [1:0]  speed_10           = 2'b00;
  localparam logic [1:0]  speed_100          = 2'b01;
  localparam logic [1:0]  speed_1000         = 2'b10;
  localparam logic [1:0]  speed_reserved     = 2'b11;
  // AXI responses
  localparam logic [1:0]  resp_okay          = 2'b00;
  localparam logic [1:0]  resp_slverr        = 2'b10;
endpackage

// ---- src/event_latch.sv ----
// Latched-high event bits, cleared on read or by write-one-to-clear
`timescale 1ns/100ps
module event_latch #(
  parameter int width = 16
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Event sources and clears
  input  wire logic [width-1:0] set_pulse,
  input  wire logic [width-1:0] clear_mask,
  // Latched state
  output logic      [width-1:0] latched_reg
);
  initial begin
    if (width < 1) $error("event_latch: width must be positive");
  end

  // A set in the clear cycle wins, so no event is lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latched_reg <= '0;
    end else begin
      latched_reg <= (latched_reg & ~clear_mask) | set_pulse;
    end
  end
endmodule

// ---- src/phy_link_status_interrupt_enable_regs.sv ----
// Link status register, event enable register and interrupt pin logic
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
// Notes on behaviour
// - Speed field gives resolved rate: 00 ten, 01 hundred, 10 gigabit.
// - Duplex bit is one for full duplex, zero for half.
// - Resolved bit is one when negotiation completed or disabled.
// - Link bit is one while link is up.
// - Downshift bit is one only during negotiation with gigabit masked.
// - Sleep bit is one while the PHY sleeps.
// - Four pair polarity bits D,C,B,A, one means reversed, gigabit only.
// - Ten megabit polarity bit is one when polarity is normal.
// - Jabber bit is one while jabber is present.
// - Status register resets to zero and is read-only.
// - An enabled event raises the interrupt while the global enable bit is set.
// - Sixteen enable bits mirror the event status bits.
// - Enable register resets to zero.
// - Event bits record events since last read, enabled or not.
// - Interrupt pin polarity selectable, active low by default.
module phy_link_status_interrupt_enable_regs #(
  parameter int addr_width = 10
) (
  // Clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // AXI4-Lite write address
  input  wire logic [addr_width-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [addr_width-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // PHY state levels
  input  wire logic [1:0]            speed_code,
  input  wire logic                  full_half_flag,
  input  wire logic                  negotiation_resolved,
  input  wire logic                  negotiation_active,
  input  wire logic                  link_up,
  input  wire logic                  crossover_pairs_cd,
  input  wire logic                  crossover_pairs_ab,
  input  wire logic                  downshift_active,
  input  wire logic                  sleep_state,
  input  wire logic [3:0]            pair_polarity_field,
  input  wire logic                  ten_polarity_normal,
  input  wire logic                  jabber_present,
  // One-cycle event pulses, one per status bit
  input  wire logic [15:0]           event_pulse,
  // Interrupt pin, polarity as programmed
  output logic                       irq_pin
);
  initial begin
    if (addr_width < 10) $error("addr_width must be at least 10");
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers and internal state

  logic [15:0] irq_enable_reg;
  logic [15:0] irq_control_reg;
  logic [15:0] level_reg;
  logic [15:0] events_latched;
  logic [15:0] event_clear;
  logic [15:0] page_set;
  logic [15:0] page_clear;
  logic [15:0] page_latched;
  logic [15:0] live_status;
  logic        wr_fire;
  logic        rd_fire;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [addr_width-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        irq_active;

  // Word address decode, upper bits must be zero
  function automatic logic hit(input logic [addr_width-1:0] a,
                               input logic [9:0] target);
    return a == addr_width'(target);
  endfunction

  // Byte-lane merge for a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    return {strb[1] ? data[15:8] : old[15:8],
            strb[0] ? data[7:0] : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Live status sampling

  // Sampled once so the bus sees a stable word
  always_comb begin
    live_status = phy_regs_pkg::link_status_reset;
    live_status[phy_regs_pkg::speed_hi_bit:phy_regs_pkg::speed_lo_bit] =
      speed_code;
    live_status[phy_regs_pkg::full_half_bit] = full_half_flag;
    live_status[phy_regs_pkg::resolved_bit] = negotiation_resolved;
    live_status[phy_regs_pkg::link_up_bit] = link_up;
    live_status[phy_regs_pkg::cross_cd_bit] = crossover_pairs_cd;
    live_status[phy_regs_pkg::cross_ab_bit] = crossover_pairs_ab;
    live_status[phy_regs_pkg::downshift_bit] =
      downshift_active & negotiation_active;
    live_status[phy_regs_pkg::sleep_bit] = sleep_state;
    // Pair polarity only means something on a gigabit link
    if (speed_code == phy_regs_pkg::speed_1000 && link_up) begin
      live_status[phy_regs_pkg::polarity_hi_bit:
                  phy_regs_pkg::polarity_lo_bit] =
        pair_polarity_field;
    end
    live_status[phy_regs_pkg::ten_polarity_bit] =
      ten_polarity_normal;
    live_status[phy_regs_pkg::jabber_bit] = jabber_present;
  end

  // Level fields, read-only, reset to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_reg <= phy_regs_pkg::link_status_reset;
    end else begin
      level_reg <= live_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Latched-high bits

  assign page_set = {3'b000, event_pulse[phy_regs_pkg::page_bit], 12'h000};
  assign page_clear = (rd_fire && hit(s_axi_araddr,
                       phy_regs_pkg::link_status_addr)) ? 16'hffff : 16'h0000;

  // Page-received flag of the link status word
  event_latch #(.width(16)) page_latch (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .set_pulse   (page_set),
    .clear_mask  (page_clear),
    .latched_reg (page_latched)
  );

  // Event bits clear on read, or by writing ones
  always_comb begin
    event_clear = 16'h0000;
    if (rd_fire && hit(s_axi_araddr, phy_regs_pkg::event_status_addr)) begin
      event_clear = 16'hffff;
    end else if (wr_fire && hit(aw_addr_reg,
                 phy_regs_pkg::event_status_addr)) begin
      event_clear = merge(16'h0000, w_data_reg, w_strb_reg);
    end
  end

  // Latch regardless of enable state
  event_latch #(.width(16)) event_bits (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .set_pulse   (event_pulse),
    .clear_mask  (event_clear),
    .latched_reg (events_latched)
  );

  ////////////////////////////////////////////////////////////////////////
  // Write channel

  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

  // Address and data accepted in either order, one write in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // Ready drops once a beat is held, until the response is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready)
                       && !s_axi_bvalid;
      s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready)
                       && !s_axi_bvalid;
    end
  end

  // Write response; status register refuses writes with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= phy_regs_pkg::resp_okay;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      if (hit(aw_addr_reg, phy_regs_pkg::irq_enable_addr) ||
          hit(aw_addr_reg, phy_regs_pkg::event_status_addr) ||
          hit(aw_addr_reg, phy_regs_pkg::irq_control_addr) ||
          hit(aw_addr_reg, phy_regs_pkg::event_test_addr)) begin
        s_axi_bresp <= phy_regs_pkg::resp_okay;
      end else begin
        s_axi_bresp <= phy_regs_pkg::resp_slverr;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Enable register, sixteen read-write bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_reg <= phy_regs_pkg::irq_enable_reset;
    end else if (wr_fire && hit(aw_addr_reg,
                 phy_regs_pkg::irq_enable_addr)) begin
      irq_enable_reg <= merge(irq_enable_reg, w_data_reg,
                              w_strb_reg);
    end
  end

  // Global enable and pin polarity
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_control_reg <= phy_regs_pkg::irq_control_reset;
    end else if (wr_fire && hit(aw_addr_reg,
                 phy_regs_pkg::irq_control_addr)) begin
      irq_control_reg <= merge(irq_control_reg, w_data_reg, w_strb_reg)
                         & 16'h2001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read channel

  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !rd_fire;
    end
  end

  // Data captured with the read so clear-on-read loses nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= phy_regs_pkg::resp_okay;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= phy_regs_pkg::resp_okay;
      if (hit(s_axi_araddr, phy_regs_pkg::link_status_addr)) begin
        s_axi_rdata <= {16'h0000, level_reg | page_latched};
      end else if (hit(s_axi_araddr, phy_regs_pkg::irq_enable_addr)) begin
        s_axi_rdata <= {16'h0000, irq_enable_reg};
      end else if (hit(s_axi_araddr, phy_regs_pkg::event_status_addr)) begin
        s_axi_rdata <= {16'h0000, events_latched};
      end else if (hit(s_axi_araddr, phy_regs_pkg::irq_control_addr)) begin
        s_axi_rdata <= {16'h0000, irq_control_reg};
      end else if (hit(s_axi_araddr, phy_regs_pkg::event_test_addr)) begin
        s_axi_rdata <= 32'h0000_0000;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= phy_regs_pkg::resp_slverr;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt pin

  // Held while any enabled latched event remains and the global enable bit is set
  assign irq_active = |(events_latched & irq_enable_reg) &&
                      irq_control_reg[phy_regs_pkg::global_enable_bit];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_pin <= 1'b1;
    end else begin
      irq_pin <= irq_active ^
                 irq_control_reg[phy_regs_pkg::polarity_bit];
    end
  end
endmodule

// ---- verification/phy_link_status_interrupt_enable_regs_sva.sv ----
// Checker for bus handshakes, register map and interrupt pin idle level
`timescale 1ns/100ps
module regs_checker #(
  parameter int addr_width = 10
) (
  // Clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // Register bus
  input wire logic [addr_width-1:0] s_axi_awaddr,
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic [31:0]           s_axi_wdata,
  input wire logic [3:0]            s_axi_wstrb,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic [1:0]            s_axi_bresp,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [addr_width-1:0] s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  input wire logic                  s_axi_rready,
  // Interrupt pin
  input wire logic                  irq_pin
);
  logic [addr_width-1:0] aw_q;
  logic [addr_width-1:0] ar_q;
  logic [15:0]           wd_q;
  logic [1:0]            ws_q;
  logic [15:0]           en_q;
  logic                  ar_mapped;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Shadow of the enable register; one write in flight keeps it exact
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= phy_regs_pkg::irq_enable_reset;
    end else if (s_axi_bvalid && s_axi_bready
                 && aw_q == phy_regs_pkg::irq_enable_addr) begin
      en_q <= {ws_q[1] ? wd_q[15:8] : en_q[15:8],
               ws_q[0] ? wd_q[7:0] : en_q[7:0]};
    end
  end
  // Captured request fields
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
    if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
    if (s_axi_wvalid && s_axi_wready) wd_q <= s_axi_wdata[15:0];
    if (s_axi_wvalid && s_axi_wready) ws_q <= s_axi_wstrb[1:0];
  end
  assign ar_mapped = ar_q inside {phy_regs_pkg::link_status_addr,
    phy_regs_pkg::irq_enable_addr, phy_regs_pkg::event_status_addr,
    phy_regs_pkg::irq_control_addr, phy_regs_pkg::event_test_addr};
  a_bvalid_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rvalid_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_status_ro: assert property (
    s_axi_bvalid && aw_q == phy_regs_pkg::link_status_addr
    |-> s_axi_bresp == phy_regs_pkg::resp_slverr)
    else $error("status write accepted");
  a_enable_readback: assert property (
    s_axi_rvalid && ar_q == phy_regs_pkg::irq_enable_addr
    |-> s_axi_rdata == {16'h0000, en_q})
    else $error("enable readback wrong");
  a_unmapped_err: assert property (
    s_axi_rvalid && !ar_mapped
    |-> s_axi_rresp == phy_regs_pkg::resp_slverr && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_irq_idle_reset: assert property (
    $rose(aresetn) |-> irq_pin)
    else $error("interrupt pin active after reset");
  a_write_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken with response pending");
endmodule
bind phy_link_status_interrupt_enable_regs regs_checker #(
  .addr_width(addr_width)
) regs_checker_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .irq_pin(irq_pin));

// ---- verification/phy_core_model.sv ----
// Model of the PHY core: state levels and one-cycle event pulses
`timescale 1ns/100ps
module phy_core_model (
  // Clock and reset
  input wire logic  aclk,
  input wire logic  aresetn,
  // Commands from the bench
  input wire logic [15:0] level_word,
  input wire logic [15:0] pulse_bits,
  input wire logic        pulse_go,
  // Core outputs
  output logic [15:0] levels,
  output logic [15:0] event_pulse
);
  // Registered so levels change only just after an edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      levels      <= 16'h0000;
      event_pulse <= 16'h0000;
    end else begin
      levels      <= level_word;
      event_pulse <= pulse_go ? pulse_bits : 16'h0000;
    end
  end
endmodule

// ---- verification/tb_phy_link_status_interrupt_enable_regs.sv ----
// Self-checking bench for the link status and event enable bank
`timescale 1ns/100ps
module tb_phy_link_status_interrupt_enable_regs;
  typedef struct {logic [31:0] data; logic [31:0] mask; logic [1:0] resp;}
    note_type;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [9:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = '0, strbs [4] = '{4'hf, 4'h1, 4'h2, 4'hc};
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid, irq_pin;
  logic [1:0]  bresp, rresp, bq [$];
  logic [15:0] level_word = '0, pulse_bits = '0, levels, event_pulse, w, en;
  logic        pulse_go = 0;
  note_type    rq [$], n;
  int          err_total = 0, total_checks = 0, cycles = 0, seed = 32'he92d;
  localparam logic [1:0] ok = phy_regs_pkg::resp_okay;
  localparam logic [1:0] er = phy_regs_pkg::resp_slverr;
  localparam logic [9:0] ls = phy_regs_pkg::link_status_addr;
  localparam logic [9:0] ie = phy_regs_pkg::irq_enable_addr;
  localparam logic [9:0] ev = phy_regs_pkg::event_status_addr;
  localparam logic [9:0] ct = phy_regs_pkg::irq_control_addr;
  phy_core_model phy_core_model_inst (.aclk(aclk), .aresetn(aresetn),
    .level_word(level_word), .pulse_bits(pulse_bits), .pulse_go(pulse_go),
    .levels(levels), .event_pulse(event_pulse));
  phy_link_status_interrupt_enable_regs phy_link_status_interrupt_enable_regs_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .speed_code(levels[1:0]),
    .full_half_flag(levels[2]), .negotiation_resolved(levels[3]),
    .negotiation_active(levels[4]), .link_up(levels[5]),
    .crossover_pairs_cd(levels[6]), .crossover_pairs_ab(levels[7]),
    .downshift_active(levels[8]), .sleep_state(levels[9]),
    .pair_polarity_field(levels[13:10]), .ten_polarity_normal(levels[14]),
    .jabber_present(levels[15]), .event_pulse(event_pulse),
    .irq_pin(irq_pin));
  always #25 aclk = ~aclk;
  task automatic check(input string what, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      complete_run();
    end
  end
  // Monitor: each answer is matched with the oldest note
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready) begin
      n = rq.pop_front();
      check("rdata", n.data & n.mask, rdata & n.mask);
      check("rresp", {30'h0, n.resp}, {30'h0, rresp});
    end
    if (bvalid === 1'b1 && bready)
      check("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
  end
  task automatic wr(input logic [9:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] r);
    bit a_ok = 0, w_ok = 0;
    bq.push_back(r);
    @(posedge aclk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, s, 3'b111};
    while (!(a_ok && w_ok)) begin
      @(posedge aclk);
      // Release each channel by NBA so the slave still sees it this edge
      if (!a_ok && awready === 1'b1) begin
        a_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] d, m,
                    input logic [1:0] r);
    rq.push_back('{d, m, r});
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask
  task automatic fire(input logic [15:0] bits);
    @(posedge aclk);
    {pulse_bits, pulse_go} <= {bits, 1'b1};
    @(posedge aclk);
    pulse_go <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  function automatic logic [31:0] status_of(input logic [15:0] v);
    logic [3:0] pol;
    pol = (v[1:0] == phy_regs_pkg::speed_1000 && v[5]) ? v[13:10] : 4'h0;
    return {16'h0, v[1:0], v[2], 1'b0, v[3], v[5], v[6], v[7],
            v[8] & v[4], v[9], pol, v[14], v[15]};
  endfunction
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ls, 32'h0, '1, ok);
    rd(ie, 32'h0, '1, ok);
    rd(ev, 32'h0, '1, ok);
    rd(ct, 32'h2000, '1, ok);
    $display("test reset_values done");
    en = 16'h0;
    for (int i = 0; i < 4; i++) begin
      w = $random(seed);
      if (strbs[i][0]) en[7:0] = w[7:0];
      if (strbs[i][1]) en[15:8] = w[15:8];
      wr(ie, {~w, w}, strbs[i], ok);
      rd(ie, {16'h0, en}, '1, ok);
    end
    wr(10'h3fc, 32'h1, 4'hf, er);
    rd(10'h3fc, 32'h0, '1, er);
    wr(ls, 32'hffff, 4'hf, er);
    rd(ls, 32'h0, '1, ok);
    wr(phy_regs_pkg::event_test_addr, 32'hffff, 4'hf, ok);
    rd(phy_regs_pkg::event_test_addr, 32'h0, '1, ok);
    $display("test register_access done");
    for (int i = 0; i < 6; i++) begin
      w = $random(seed);
      w[1:0] = i / 2;
      w[5] = i[0];
      level_word <= w;
      repeat (5) @(posedge aclk);
      rd(ls, status_of(w), '1, ok);
    end
    $display("test status_fields done");
    fire(16'h1000);
    rd(ls, 32'h1000, 32'h1000, ok);
    rd(ls, 32'h0, 32'h1000, ok);
    rd(ev, 32'h1000, '1, ok);
    wr(ct, 32'h2001, 4'hf, ok);
    wr(ie, 32'h0400, 4'h3, ok);
    fire(16'h0020);
    check("irq_pin", 32'h1, {31'h0, irq_pin});
    fire(16'h0400);
    check("irq_pin", 32'h0, {31'h0, irq_pin});
    rd(ev, 32'h0420, '1, ok);
    repeat (4) @(posedge aclk);
    check("irq_pin", 32'h1, {31'h0, irq_pin});
    wr(ct, 32'h0001, 4'hf, ok);
    repeat (4) @(posedge aclk);
    check("irq_pin", 32'h0, {31'h0, irq_pin});
    fire(16'h0400);
    check("irq_pin", 32'h1, {31'h0, irq_pin});
    wr(ev, 32'h0400, 4'h3, ok);
    repeat (4) @(posedge aclk);
    check("irq_pin", 32'h0, {31'h0, irq_pin});
    $display("test interrupt done");
    // Reset in mid-run must bring enables and pin polarity back
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    check("irq_pin", 32'h1, {31'h0, irq_pin});
    rd(ie, 32'h0, '1, ok);
    rd(ct, 32'h2000, '1, ok);
    $display("test mid_reset done");
    complete_run();
  end
endmodule
